// ==== include/adc_ctl_pkg.sv ====
/*
  Constants and types shared by the converter control block and its sample averager.
  Assumes a 12-bit byte-address register port with 8-bit data.
*/
`default_nettype none
package adc_ctl_pkg;
  // ************************************************************
  // register addresses
  // ************************************************************
  localparam logic [11:0] ADDR_CMD_CTL  = 12'hF70;
  localparam logic [11:0] ADDR_MODE_CTL = 12'hF71;
  localparam logic [11:0] ADDR_RES_LO   = 12'hF72;
  localparam logic [11:0] ADDR_RES_HI   = 12'hF73;
  localparam logic [11:0] ADDR_UP_LO    = 12'hF74;
  localparam logic [11:0] ADDR_UP_HI    = 12'hF75;
  localparam logic [11:0] ADDR_DN_LO    = 12'hF76;
  localparam logic [11:0] ADDR_DN_HI    = 12'hF77;
  localparam logic [11:0] ADDR_CHAN_LO  = 12'hF78;
  localparam logic [11:0] ADDR_CHAN_HI  = 12'hF79;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CMD_HI      = 7;
  localparam int CMD_LO      = 6;
  localparam int DMA_SEL_BIT = 5;
  localparam int IRQ_SEL_BIT = 4;
  localparam int REPEAT_BIT  = 3;
  localparam int AVG_ON_BIT  = 2;
  localparam int AVG_CNT_HI  = 1;
  localparam int AVG_CNT_LO  = 0;
  localparam int POWER_HI    = 7;
  localparam int POWER_LO    = 6;
  localparam int SCAN_BIT    = 5;
  localparam int TOPO_HI     = 4;
  localparam int TOPO_LO     = 3;
  localparam int SIGN_BIT    = 2;
  localparam int RES_BIT     = 1;
  localparam int TRIM_BIT    = 0;

  // ************************************************************
  // reset values, codes and widths
  // ************************************************************
  localparam logic [7:0]  CTL_RESET      = 8'h00;
  localparam logic [15:0] WORD_RESET     = 16'h0000;
  localparam logic [15:0] WIN_UP_RESET   = 16'hFFFF;
  localparam logic [1:0]  CMD_IDLE       = 2'h0;
  localparam logic [1:0]  CMD_CONVERT    = 2'h1;
  localparam logic [1:0]  CMD_OFFSET_CAL = 2'h2;
  localparam logic [1:0]  CMD_GAIN_CAL   = 2'h3;
  localparam logic [15:0] MID_12         = 16'h0800;
  localparam logic [15:0] MID_14         = 16'h2000;
  localparam int          RAW_W          = 14;
  localparam int          ACC_W          = 18;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_SAMPLE = 2'h1,
    ST_RESULT = 2'h3
  } seq_state_t;
endpackage : adc_ctl_pkg
`default_nettype wire

// ==== rtl/sample_averager.sv ====
/*
  Sums converted samples and presents the sum divided by a power of two.
  Assumes clear and add never overlap and at most 16 samples per sum.
*/
`timescale 1ns/1ps
`default_nettype none
module sample_averager (
  input  wire logic                            clk,
  input  wire logic                            sys_rst,
  input  wire logic                            clear,
  input  wire logic                            add,
  input  wire logic [adc_ctl_pkg::RAW_W-1:0]   sample,
  input  wire logic [2:0]                      shift,
  output logic      [15:0]                     average
);
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [adc_ctl_pkg::ACC_W-1:0] acc;
  } avg_state_t;

  avg_state_t cur;
  avg_state_t next_cur;

  // clear restarts the sum, add folds in one sample
  always_comb begin
    next_cur = cur;
    if (clear) begin
      next_cur.acc = '0;
    end else if (add) begin
      next_cur.acc = cur.acc + adc_ctl_pkg::ACC_W'(sample);
    end
  end

  // register the state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // divide by the sample count; sixteen full-scale samples still fit
  assign average = 16'(cur.acc >> shift);
endmodule : sample_averager
`default_nettype wire

// ==== rtl/adc_control_registers.sv ====
/*
  Control registers and sequencer of an on-chip converter: command/busy, calibration,
  averaging, scanning, result bytes, window check, DMA request and interrupt pulse.
  Assumes the analog core runs on clk and answers each conv_start with one conv_done.
*/
// The address-and-strobe port was left to the implementer.
// Functional notes
// - command field reads 00 when the converter is idle and ready
// - writing 01 starts a conversion; field reads 01 while it runs
// - writing 10 starts offset calibration; field reads 10 while running
// - writing 11 starts gain calibration; field reads 11 while running
// - with DMA clear select 0, reading the low result byte drops DMA request
// - with DMA clear select 1, reading the high result byte drops it instead
// - interrupt select 0: window only; 1: end of conversion and window
// - averaging on makes each result the average of several samples
// - averaging count codes 00..11 select 2, 4, 8 or 16 samples
// - power field 00 fast, 10 low power; 01 and 11 reserved
// - scan enable sequences through channels in the two channel selects
// - input topology field selects one of four input modes
// - format bit 1 gives sign-extended two's complement, 0 unsigned
// - resolution bit 0 gives 12-bit, 1 gives two-pass 14-bit
// - command field returns to 00 when a calibration completes
// - window interrupt when a new result is above upper or below lower
// - DMA request on every new conversion result, never on calibration
`timescale 1ns/1ps
`default_nettype none
module adc_control_registers (
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  input  wire logic [11:0]                   bus_addr,
  input  wire logic [7:0]                    bus_wr_data,
  input  wire logic                          bus_wr_en,
  input  wire logic                          bus_rd_en,
  output logic      [7:0]                    bus_rd_data,
  input  wire logic                          conv_done,
  input  wire logic [adc_ctl_pkg::RAW_W-1:0] conv_data,
  output logic                               conv_start,
  output logic      [1:0]                    conv_operation,
  output logic      [3:0]                    conv_channel,
  output logic                               conv_resolution,
  output logic      [1:0]                    conv_topology,
  output logic      [1:0]                    conv_power,
  output logic                               conv_trim_enable,
  output logic                               dma_req,
  output logic                               irq_req
);
  // ************************************************************
  // state and helpers
  // ************************************************************
  typedef struct packed {
    logic [7:0]                   ctl0;
    logic [7:0]                   ctl1;
    logic [7:0]                   chan_lo;
    logic [7:0]                   chan_hi;
    logic [15:0]                  win_up;
    logic [15:0]                  win_dn;
    logic [15:0]                  result;
    logic [7:0]                   rd_data;
    adc_ctl_pkg::seq_state_t      st;
    logic [3:0]                   chan;
    logic [4:0]                   left;
    logic                         acc_clear;
    logic                         start;
    logic                         dma;
    logic                         irq;
  } ctl_state_t;

  ctl_state_t cur;
  ctl_state_t next_cur;
  logic [15:0] average;

  // lowest selected channel at or above from; bit 4 set when one exists
  function automatic logic [4:0] find_chan(input logic [15:0] mask, input logic [4:0] from);
    logic [4:0] hit;
    hit = 5'h00;
    for (int i = 15; i >= 0; i--) begin
      if (mask[i] && (5'(i) >= from)) begin
        hit = {1'b1, 4'(i)};
      end
    end
    return hit;
  endfunction : find_chan

  // samples per result: one, or 2, 4, 8, 16 when averaging
  function automatic logic [4:0] sample_target(input logic [7:0] c0);
    logic [4:0] n;
    n = 5'h01;
    if (c0[adc_ctl_pkg::AVG_ON_BIT]) begin
      n = 5'(5'h02 << c0[adc_ctl_pkg::AVG_CNT_HI:adc_ctl_pkg::AVG_CNT_LO]);
    end
    return n;
  endfunction : sample_target

  // readback multiplexer
  function automatic logic [7:0] read_mux(input ctl_state_t s, input logic [11:0] a);
    logic [7:0] d;
    d = 8'h00;
    case (a)
      adc_ctl_pkg::ADDR_CMD_CTL:  d = s.ctl0;
      adc_ctl_pkg::ADDR_MODE_CTL: d = s.ctl1;
      adc_ctl_pkg::ADDR_RES_LO:   d = s.result[7:0];
      adc_ctl_pkg::ADDR_RES_HI:   d = s.result[15:8];
      adc_ctl_pkg::ADDR_UP_LO:    d = s.win_up[7:0];
      adc_ctl_pkg::ADDR_UP_HI:    d = s.win_up[15:8];
      adc_ctl_pkg::ADDR_DN_LO:    d = s.win_dn[7:0];
      adc_ctl_pkg::ADDR_DN_HI:    d = s.win_dn[15:8];
      adc_ctl_pkg::ADDR_CHAN_LO:  d = s.chan_lo;
      adc_ctl_pkg::ADDR_CHAN_HI:  d = s.chan_hi;
      default:                    d = 8'h00;
    endcase
    return d;
  endfunction : read_mux

  // ************************************************************
  // averaging accumulator
  // ************************************************************
  logic [2:0] avg_shift;
  logic       avg_add;

  // divide by the count: shift is one more than the count code
  always_comb begin
    avg_shift = 3'h0;
    if (cur.ctl0[adc_ctl_pkg::AVG_ON_BIT]) begin
      avg_shift = 3'(cur.ctl0[adc_ctl_pkg::AVG_CNT_HI:adc_ctl_pkg::AVG_CNT_LO]) + 3'h1;
    end
  end

  assign avg_add = conv_done && (cur.st == adc_ctl_pkg::ST_SAMPLE)
                   && (cur.ctl0[adc_ctl_pkg::CMD_HI:adc_ctl_pkg::CMD_LO]
                       == adc_ctl_pkg::CMD_CONVERT);

  sample_averager u_avg (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clear   (cur.acc_clear),
    .add     (avg_add),
    .sample  (conv_data),
    .shift   (avg_shift),
    .average (average)
  );

  // ************************************************************
  // register file and sequencer
  // ************************************************************
  logic [1:0]  cmd;
  logic [15:0] mask;
  logic [15:0] uns_val;
  logic [15:0] fmt_val;
  logic [4:0]  first_hit;
  logic [4:0]  next_hit;
  logic        is_cal;
  logic        dma_clear;
  logic        restart;
  logic        out_window;

  // decode of current settings
  always_comb begin
    cmd       = cur.ctl0[adc_ctl_pkg::CMD_HI:adc_ctl_pkg::CMD_LO];
    mask      = {cur.chan_hi, cur.chan_lo};
    first_hit = find_chan(mask, 5'h00);
    next_hit  = find_chan(mask, 5'({1'b0, cur.chan}) + 5'h01);
    is_cal    = (cmd == adc_ctl_pkg::CMD_OFFSET_CAL) || (cmd == adc_ctl_pkg::CMD_GAIN_CAL);
    // result width follows the resolution bit
    if (cur.ctl1[adc_ctl_pkg::RES_BIT]) begin
      uns_val = {2'b00, average[13:0]};
      fmt_val = uns_val - adc_ctl_pkg::MID_14;
    end else begin
      uns_val = {4'h0, average[11:0]};
      fmt_val = uns_val - adc_ctl_pkg::MID_12;
    end
    if (!cur.ctl1[adc_ctl_pkg::SIGN_BIT]) begin
      fmt_val = uns_val;
    end
    out_window = (uns_val > cur.win_up) || (uns_val < cur.win_dn);
    // DMA request drops on a read of the selected result byte
    if (cur.ctl0[adc_ctl_pkg::DMA_SEL_BIT]) begin
      dma_clear = bus_rd_en && (bus_addr == adc_ctl_pkg::ADDR_RES_HI);
    end else begin
      dma_clear = bus_rd_en && (bus_addr == adc_ctl_pkg::ADDR_RES_LO);
    end
  end

  // next state: bus writes, sequencing, events
  always_comb begin
    next_cur           = cur;
    next_cur.start     = 1'b0;
    next_cur.acc_clear = 1'b0;
    next_cur.irq       = 1'b0;
    restart            = 1'b0;
    if (bus_rd_en) begin
      next_cur.rd_data = read_mux(cur, bus_addr);
    end
    if (dma_clear) begin
      next_cur.dma = 1'b0;
    end
    // software writes; the command field only takes a launch while idle
    if (bus_wr_en) begin
      case (bus_addr)
        adc_ctl_pkg::ADDR_CMD_CTL: begin
          next_cur.ctl0[5:0] = bus_wr_data[5:0];
          if (cur.st == adc_ctl_pkg::ST_IDLE) begin
            next_cur.ctl0[adc_ctl_pkg::CMD_HI:adc_ctl_pkg::CMD_LO] =
              bus_wr_data[adc_ctl_pkg::CMD_HI:adc_ctl_pkg::CMD_LO];
          end
        end
        adc_ctl_pkg::ADDR_MODE_CTL: next_cur.ctl1 = bus_wr_data;
        adc_ctl_pkg::ADDR_UP_LO:    next_cur.win_up[7:0] = bus_wr_data;
        adc_ctl_pkg::ADDR_UP_HI:    next_cur.win_up[15:8] = bus_wr_data;
        adc_ctl_pkg::ADDR_DN_LO:    next_cur.win_dn[7:0] = bus_wr_data;
        adc_ctl_pkg::ADDR_DN_HI:    next_cur.win_dn[15:8] = bus_wr_data;
        adc_ctl_pkg::ADDR_CHAN_LO:  next_cur.chan_lo = bus_wr_data;
        adc_ctl_pkg::ADDR_CHAN_HI:  next_cur.chan_hi = bus_wr_data;
        default: begin
        end
      endcase
    end
    case (cur.st)
      // a nonzero command written while idle launches the sequence
      adc_ctl_pkg::ST_IDLE: begin
        if (bus_wr_en && (bus_addr == adc_ctl_pkg::ADDR_CMD_CTL)
            && (bus_wr_data[adc_ctl_pkg::CMD_HI:adc_ctl_pkg::CMD_LO]
                != adc_ctl_pkg::CMD_IDLE)) begin
          next_cur.chan = first_hit[3:0];
          restart       = 1'b1;
        end
      end
      // wait for the core; calibration ends on its one answer
      adc_ctl_pkg::ST_SAMPLE: begin
        if (conv_done) begin
          if (is_cal) begin
            next_cur.result = {2'b00, conv_data};
            next_cur.ctl0[adc_ctl_pkg::CMD_HI:adc_ctl_pkg::CMD_LO] =
              adc_ctl_pkg::CMD_IDLE;
            next_cur.irq = cur.ctl0[adc_ctl_pkg::IRQ_SEL_BIT];
            next_cur.st  = adc_ctl_pkg::ST_IDLE;
          end else if (cur.left == 5'h01) begin
            next_cur.st = adc_ctl_pkg::ST_RESULT;
          end else begin
            next_cur.left  = cur.left - 5'h01;
            next_cur.start = 1'b1;
          end
        end
      end
      // publish the result, then scan on, repeat or stop
      adc_ctl_pkg::ST_RESULT: begin
        next_cur.result = fmt_val;
        next_cur.dma    = 1'b1;
        next_cur.irq    = cur.ctl0[adc_ctl_pkg::IRQ_SEL_BIT] || out_window;
        if (cur.ctl1[adc_ctl_pkg::SCAN_BIT] && next_hit[4]) begin
          next_cur.chan = next_hit[3:0];
          restart       = 1'b1;
        end else if (cur.ctl0[adc_ctl_pkg::REPEAT_BIT]) begin
          next_cur.chan = first_hit[3:0];
          restart       = 1'b1;
        end else begin
          next_cur.ctl0[adc_ctl_pkg::CMD_HI:adc_ctl_pkg::CMD_LO] =
            adc_ctl_pkg::CMD_IDLE;
          next_cur.st = adc_ctl_pkg::ST_IDLE;
        end
      end
      default: begin
        next_cur.st = adc_ctl_pkg::ST_IDLE;
      end
    endcase
    // start a fresh result: clear the sum, load the count, fire the core
    if (restart) begin
      next_cur.left      = sample_target(next_cur.ctl0);
      next_cur.acc_clear = 1'b1;
      next_cur.start     = 1'b1;
      next_cur.st        = adc_ctl_pkg::ST_SAMPLE;
    end
  end

  // register the state; reset clears everything except the upper window bound, which loads FFFF
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cur         <= '0;
      cur.ctl0    <= adc_ctl_pkg::CTL_RESET;
      cur.ctl1    <= adc_ctl_pkg::CTL_RESET;
      cur.win_up  <= adc_ctl_pkg::WIN_UP_RESET;
      cur.win_dn  <= adc_ctl_pkg::WORD_RESET;
      cur.st      <= adc_ctl_pkg::ST_IDLE;
    end else begin
      cur <= next_cur;
    end
  end

  // ************************************************************
  // outputs, all from flip-flops
  // ************************************************************
  assign bus_rd_data      = cur.rd_data;
  assign conv_start       = cur.start;
  assign conv_operation   = cur.ctl0[adc_ctl_pkg::CMD_HI:adc_ctl_pkg::CMD_LO];
  assign conv_channel     = cur.chan;
  assign conv_resolution  = cur.ctl1[adc_ctl_pkg::RES_BIT];
  assign conv_topology    = cur.ctl1[adc_ctl_pkg::TOPO_HI:adc_ctl_pkg::TOPO_LO];
  assign conv_power       = cur.ctl1[adc_ctl_pkg::POWER_HI:adc_ctl_pkg::POWER_LO];
  assign conv_trim_enable = cur.ctl1[adc_ctl_pkg::TRIM_BIT];
  assign dma_req          = cur.dma;
  assign irq_req          = cur.irq;
endmodule : adc_control_registers
`default_nettype wire

// ==== sim/adc_ctl_monitor.sv ====
/*
  Port checks for the converter control registers.
  Assumes a bind onto adc_control_registers, one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_ctl_monitor (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [11:0] bus_addr,
  input wire logic [7:0]  bus_wr_data,
  input wire logic        bus_wr_en,
  input wire logic        bus_rd_en,
  input wire logic [7:0]  bus_rd_data,
  input wire logic        conv_done,
  input wire logic        conv_start,
  input wire logic [1:0]  conv_operation,
  input wire logic        conv_resolution,
  input wire logic [1:0]  conv_topology,
  input wire logic [1:0]  conv_power,
  input wire logic        conv_trim_enable,
  input wire logic        dma_req,
  input wire logic        irq_req
);
  // ********
  // helper logic
  // ********
  logic       dma_hi;
  logic       wr_cmd;
  logic       rd_cmd;
  logic [5:0] mode_in;
  logic [1:0] cmd_in;
  // register hits and mode bits as written
  assign cmd_in  = bus_wr_data[7:6];
  assign wr_cmd  = bus_wr_en && bus_addr == adc_ctl_pkg::ADDR_CMD_CTL;
  assign rd_cmd  = bus_rd_en && bus_addr == adc_ctl_pkg::ADDR_CMD_CTL;
  assign mode_in = {bus_wr_data[7:6], bus_wr_data[4:3], bus_wr_data[1:0]};
  // shadow of the dma clear select bit
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dma_hi <= 1'b0;
    end else if (wr_cmd) begin
      dma_hi <= bus_wr_data[5];
    end
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ********
  // checks
  // ********
  reset_clear_a:
    assert property ($fell(sys_rst) |-> !conv_start && !dma_req && !irq_req
      && conv_operation == 2'h0 && bus_rd_data == 8'h00) else $error("outputs not reset");
  launch_start_a:
    assert property (wr_cmd && bus_wr_data[7:6] != 2'h0 && conv_operation == 2'h0
      |=> conv_start && conv_operation == $past(cmd_in)) else $error("no launch");
  start_pulse_a:
    assert property (conv_start |=> !conv_start) else $error("start pulse too long");
  cmd_read_a:
    assert property (rd_cmd |=> bus_rd_data[7:6] == $past(conv_operation))
      else $error("command field does not match operation");
  dma_clear_a:
    assert property (bus_rd_en && !$past(conv_done) && bus_addr == (dma_hi ?
      adc_ctl_pkg::ADDR_RES_HI : adc_ctl_pkg::ADDR_RES_LO) |=> !dma_req)
      else $error("dma request not cleared");
  dma_keep_a:
    assert property (dma_req && bus_rd_en && bus_addr == (dma_hi ?
      adc_ctl_pkg::ADDR_RES_LO : adc_ctl_pkg::ADDR_RES_HI) |=> dma_req)
      else $error("dma request cleared by wrong byte");
  dma_cause_a:
    assert property ($rose(dma_req) |-> $past(conv_done, 2)
      && $past(conv_operation) == adc_ctl_pkg::CMD_CONVERT) else $error("dma without result");
  irq_pulse_a:
    assert property (irq_req |=> !irq_req) else $error("interrupt pulse too long");
  mode_out_a:
    assert property (bus_wr_en && bus_addr == adc_ctl_pkg::ADDR_MODE_CTL |=>
      {conv_power, conv_topology, conv_resolution, conv_trim_enable} == $past(mode_in))
      else $error("mode outputs do not follow register");
endmodule : adc_ctl_monitor
bind adc_control_registers adc_ctl_monitor i_mon (
  .clk, .sys_rst, .bus_addr, .bus_wr_data, .bus_wr_en, .bus_rd_en, .bus_rd_data, .conv_done,
  .conv_start, .conv_operation, .conv_resolution, .conv_topology, .conv_power,
  .conv_trim_enable, .dma_req, .irq_req
);
`default_nettype wire

// ==== sim/tb.sv ====
/*
  Self-checking bench for the converter control registers.
  Assumes the bench acts as register master and as the analog core.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ********
  // signals
  // ********
  localparam logic [11:0] C0 = adc_ctl_pkg::ADDR_CMD_CTL;
  localparam logic [11:0] C1 = adc_ctl_pkg::ADDR_MODE_CTL;
  localparam logic [11:0] RL = adc_ctl_pkg::ADDR_RES_LO;
  localparam logic [11:0] RH = adc_ctl_pkg::ADDR_RES_HI;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [11:0] bus_addr = 12'h000;
  logic [7:0]  bus_wr_data = 8'h00;
  logic        bus_wr_en = 1'b0;
  logic        bus_rd_en = 1'b0;
  logic        conv_done = 1'b0;
  logic [13:0] conv_data = 14'h0000;
  logic [7:0]  bus_rd_data, rv, md;
  logic [3:0]  conv_channel;
  logic [1:0]  conv_operation, conv_topology, conv_power;
  logic        conv_start, conv_resolution, conv_trim_enable, dma_req, irq_req;
  int          n_fail = 0;
  int          total_checks = 0;
  int          n_irq = 0;
  int          n_start = 0;
  int          s0 = 0;
  int          i0 = 0;
  // device under test
  adc_control_registers i_dut (
    .clk, .sys_rst, .bus_addr, .bus_wr_data, .bus_wr_en, .bus_rd_en, .bus_rd_data,
    .conv_done, .conv_data, .conv_start, .conv_operation, .conv_channel,
    .conv_resolution, .conv_topology, .conv_power, .conv_trim_enable, .dma_req, .irq_req
  );
  // clock and pulse tallies
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    n_start += int'(conv_start === 1'b1);
    n_irq += int'(irq_req === 1'b1);
  end
  // ********
  // tasks
  // ********
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  task automatic tmo;
    n_fail++;
    end_sim();
  endtask : tmo
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_wr_data <= d;
    bus_wr_en <= 1'b1;
    @(posedge clk);
    bus_wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    bus_addr <= a;
    bus_rd_en <= 1'b1;
    @(posedge clk);
    bus_rd_en <= 1'b0;
    #1 rv = bus_rd_data;
  endtask : rd
  task automatic rdc(input logic [11:0] a, input logic [7:0] e);
    rd(a);
    chk(16'(rv), 16'(e));
  endtask : rdc
  // wait for start pulse number c+1 of this launch
  task automatic wst(input int c);
    int k = 0;
    #1;
    while (n_start <= s0 + c && k < 60) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (n_start <= s0 + c) tmo();
  endtask : wst
  // answer samples f..n-1 as the core would
  task automatic feed(input int f, input int n, input logic [13:0] v);
    for (int i = f; i < n; i++) begin
      wst(i);
      @(posedge clk);
      conv_done <= 1'b1;
      conv_data <= v + 14'(i);
      @(posedge clk);
      conv_done <= 1'b0;
      conv_data <= ~(v + 14'(i));
    end
  endtask : feed
  task automatic go(input logic [7:0] c);
    s0 = n_start;
    wr(C0, c);
    rd(C0);
    chk(16'(rv[7:6]), 16'(c[7:6]));
  endtask : go
  task automatic idle;
    int k = 0;
    do begin
      rd(C0);
      k++;
    end while (rv[7:6] !== 2'b00 && k < 40);
    if (rv[7:6] !== 2'b00) tmo();
  endtask : idle
  task automatic run(input logic [7:0] c, input int n, input logic [13:0] v);
    go(c);
    feed(0, n, v);
    idle();
  endtask : run
  task automatic win(input logic [15:0] lo, input logic [15:0] up);
    wr(adc_ctl_pkg::ADDR_UP_LO, up[7:0]);
    wr(adc_ctl_pkg::ADDR_UP_HI, up[15:8]);
    wr(adc_ctl_pkg::ADDR_DN_LO, lo[7:0]);
    wr(adc_ctl_pkg::ADDR_DN_HI, lo[15:8]);
  endtask : win
  // ********
  // scenarios
  // ********
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    rdc(C0, 8'h00);
    rdc(C1, 8'h00);
    for (int j = 0; j < 4; j++) begin
      md = {j[1:0], 1'b0, j[1:0], 1'b0, j[0], 1'b1};
      wr(C1, md);
      rdc(C1, md);
      chk(16'({conv_power, conv_topology, conv_resolution}), 16'({md[7:6], md[4:3], md[1]}));
    end
    wr(C1, 8'h01);
    wr(C0, 8'h3F);
    rdc(C0, 8'h3F);
    // dma clear by low byte, interrupt at end of conversion
    i0 = n_irq;
    run(8'h50, 1, 14'h0123);
    chk(16'(dma_req), 16'h1);
    chk(16'(n_irq - i0), 16'h1);
    rdc(RH, 8'h01);
    chk(16'(dma_req), 16'h1);
    rdc(RL, 8'h23);
    chk(16'(dma_req), 16'h0);
    // dma clear by high byte, window only
    i0 = n_irq;
    run(8'h60, 1, 14'h0456);
    chk(16'(n_irq - i0), 16'h0);
    rdc(RL, 8'h56);
    chk(16'(dma_req), 16'h1);
    rdc(RH, 8'h04);
    chk(16'(dma_req), 16'h0);
    // below, on and above the window
    win(16'h0100, 16'h0200);
    for (int j = 0; j < 3; j++) begin
      i0 = n_irq;
      run(8'h40, 1, 14'h0050 + 14'(j * 'h1B0));
      chk(16'(n_irq - i0), 16'(j != 1));
    end
    win(16'h0000, 16'hFFFF);
    // offset and gain calibration
    rd(RL);
    wr(C1, 8'h03);
    for (int j = 2; j < 4; j++) begin
      i0 = n_irq;
      run({2'(j), 6'h10}, 1, 14'h0015);
      chk(16'(dma_req), 16'h0);
      chk(16'(n_irq - i0), 16'h1);
    end
    // every averaging count
    wr(C1, 8'h01);
    for (int c = 0; c < 4; c++) begin
      run(8'h44 | 8'(c), 2 << c, 14'h0100);
      chk(16'(n_start - s0), 16'(2 << c));
      rdc(RL, 8'(((2 << c) - 1) / 2));
    end
    // signed 12-bit, then 14-bit
    wr(C1, 8'h05);
    run(8'h40, 1, 14'h0700);
    rdc(RL, 8'h00);
    rdc(RH, 8'hFF);
    wr(C1, 8'h07);
    run(8'h40, 1, 14'h2005);
    rdc(RL, 8'h05);
    rdc(RH, 8'h00);
    // repeat conversion stopped in mid-run
    wr(C1, 8'h01);
    go(8'h48);
    feed(0, 2, 14'h0010);
    wst(2);
    wr(C0, 8'h00);
    feed(2, 3, 14'h0010);
    idle();
    chk(16'(n_start - s0), 16'h3);
    // scan over channels 1 and 2
    wr(adc_ctl_pkg::ADDR_CHAN_LO, 8'h06);
    wr(C1, 8'h21);
    go(8'h40);
    chk(16'(conv_channel), 16'h1);
    feed(0, 1, 14'h0020);
    wst(1);
    chk(16'(conv_channel), 16'h2);
    feed(1, 2, 14'h0020);
    idle();
    chk(16'(n_start - s0), 16'h2);
    // unmapped place, then a second reset
    wr(12'hF7A, 8'hFF);
    rdc(12'hF7A, 8'h00);
    wr(C0, 8'h3F);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rdc(C0, 8'h00);
    end_sim();
  end
  // watchdog against a hang
  initial begin
    #2000000;
    tmo();
  end
endmodule : tb
`default_nettype wire
